// [verilog/dctc_channel.sv]
// one transfer channel: trigger handling, pending request and auto-disable
`timescale 1ns/100ps
module dctc_channel (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire dctc_pkg::dctc_trig_s trig,
    input wire dctc_pkg::dctc_cfg_s cfg,
    input wire logic enableSet,
    input wire logic enableClear,
    input wire logic grant,
    input wire dctc_pkg::dctc_mover_s mover,
    output logic channelEnable,
    output logic channelPending,
    output logic channelBusy,
    output logic arbRequest,
    output logic transferStart
);
    logic [1:0] rstSync_q;
    logic rstSyncN;
    logic trigPulse;
    logic unitDone;
    logic endOfList;
    dctc_pkg::dctc_state_s s_q;
    dctc_pkg::dctc_state_s s_d;

    // two stages so every flop of the channel leaves reset on the same edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstSyncN = rstSync_q[1];

    dctc_trigger_detect u_detect (
        .sys_clk(sys_clk),
        .rstSyncN(rstSyncN),
        .trig(trig),
        .sourceSel(cfg.triggerSourceSelect),
        .trigPulse(trigPulse)
    );

    // the action decides which mover completion ends one granted transfer
    always_comb begin
        case (cfg.triggerActionSelect)
            dctc_pkg::ACT_BEAT: unitDone = mover.beatDone | mover.blockDone; // RULE3
            dctc_pkg::ACT_TRANSACTION: unitDone = mover.transactionDone | mover.blockDone; // RULE3
            // the unused code falls back to block so a bad setting never stalls the channel
            default: unitDone = mover.blockDone; // RULE3 RULE4
        endcase
    end
    assign endOfList = mover.blockDone & mover.lastDescriptor;

    always_comb begin
        s_d = s_q;
        s_d.startPulse = 1'b0;
        case (s_q.state)
            dctc_pkg::ST_OFF: begin
                if (enableSet) begin
                    s_d.channelEnable = 1'b1;
                    s_d.state = dctc_pkg::ST_WAIT; // RULE7
                end
            end
            dctc_pkg::ST_WAIT: begin
                if (trigPulse) begin
                    s_d.state = dctc_pkg::ST_REQ;
                end
            end
            dctc_pkg::ST_REQ: begin
                if (grant) begin
                    s_d.state = dctc_pkg::ST_XFER; // RULE1
                    s_d.startPulse = 1'b1;
                    s_d.busy = 1'b1;
                end
            end
            dctc_pkg::ST_XFER: begin
                // a second request while one is held is dropped
                if (trigPulse && !s_q.pending) begin
                    s_d.pending = 1'b1; // RULE8 RULE9 RULE10
                end
                if (unitDone) begin
                    s_d.busy = 1'b0;
                    if (endOfList) begin
                        // single descriptor is a list of one
                        s_d.channelEnable = 1'b0; // RULE5 RULE6
                        s_d.pending = 1'b0;
                        s_d.state = dctc_pkg::ST_OFF;
                    end else if (s_q.pending || trigPulse) begin
                        s_d.pending = 1'b0;
                        s_d.state = dctc_pkg::ST_REQ; // RULE8
                    end else begin
                        s_d.state = dctc_pkg::ST_WAIT; // RULE6
                    end
                end
            end
            default: s_d.state = dctc_pkg::ST_OFF;
        endcase
        // clear wins over a same-cycle set so software can always stop a channel
        if (enableClear) begin
            s_d.channelEnable = 1'b0;
            s_d.pending = 1'b0;
            s_d.busy = 1'b0;
            s_d.startPulse = 1'b0;
            s_d.state = dctc_pkg::ST_OFF;
        end
        s_d.arbReq = (s_d.state == dctc_pkg::ST_REQ);
    end

    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s_q <= '{state: dctc_pkg::ST_OFF, default: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign channelEnable = s_q.channelEnable;
    assign channelPending = s_q.pending;
    assign channelBusy = s_q.busy;
    assign arbRequest = s_q.arbReq;
    assign transferStart = s_q.startPulse;

    chk_start_needs_grant: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE1
        transferStart |-> $past(grant) && $past(s_q.state) == dctc_pkg::ST_REQ)
        else $error("start without grant");
    chk_auto_disable: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE5
        (channelBusy && endOfList && !enableClear) |=> !channelEnable && !channelBusy)
        else $error("channel not disabled at list end");
    chk_reenable_waits: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE7
        (s_q.state == dctc_pkg::ST_OFF && enableSet) |=> !arbRequest && !channelBusy)
        else $error("re-enabled channel started without trigger");
    chk_pending_set: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE8
        (channelBusy && trigPulse && !unitDone && !enableClear) |=> channelPending)
        else $error("request during transfer not held");
    chk_pending_served: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE8
        (channelBusy && channelPending && unitDone && !endOfList && !enableClear) |=> arbRequest)
        else $error("pending request not served");
    chk_pending_no_drop: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE10
        (channelBusy && channelPending && !unitDone && !enableClear) |=> channelPending && channelBusy)
        else $error("pending flag disturbed");
    chk_block_waits: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE4
        (cfg.triggerActionSelect == dctc_pkg::ACT_BLOCK && channelBusy && !mover.blockDone && !enableClear)
        |=> channelBusy)
        else $error("block transfer ended early");
    chk_beat_ends: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE3
        (cfg.triggerActionSelect == dctc_pkg::ACT_BEAT && channelBusy && mover.beatDone) |=> !channelBusy)
        else $error("beat transfer did not end");

    // grant may linger a cycle after the request drops; only the request state honours it
    chk_trigger_requests: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE2
        (s_q.state == dctc_pkg::ST_WAIT && trigPulse && !enableClear)
        |=> arbRequest && !channelBusy)
        else $error("trigger did not raise a request");
    chk_idle_quiet: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE7
        (s_q.state == dctc_pkg::ST_WAIT && !trigPulse && !enableClear)
        |=> !arbRequest && !channelBusy)
        else $error("waiting channel requested without trigger");
    chk_off_quiet: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE5
        !channelEnable
        |-> !arbRequest && !channelBusy && !channelPending)
        else $error("disabled channel still active");
    chk_start_busy: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE1
        transferStart
        |-> channelBusy && !arbRequest)
        else $error("start without busy");
    chk_start_single: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE1
        transferStart
        |=> !transferStart)
        else $error("start pulse longer than one cycle");
    chk_no_grant_wait: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE1
        (arbRequest && !grant && !enableClear)
        |=> arbRequest && !transferStart)
        else $error("request dropped or started without grant");
    chk_grant_starts: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE1
        (arbRequest && grant && !enableClear)
        |=> transferStart && channelBusy)
        else $error("granted request did not start");
    chk_pending_busy: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE9
        channelPending
        |-> channelBusy)
        else $error("pending flag outside a transfer");
    chk_pending_once: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE9
        (channelBusy && unitDone)
        |=> !channelPending)
        else $error("pending flag kept after transfer end");
    chk_request_ignores: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE9
        (arbRequest && trigPulse && !grant && !enableClear)
        |=> arbRequest && !channelPending)
        else $error("trigger stored while requesting");
    chk_trans_ends: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE3
        (cfg.triggerActionSelect == dctc_pkg::ACT_TRANSACTION && channelBusy && mover.transactionDone)
        |=> !channelBusy)
        else $error("transaction transfer did not end");
    chk_beat_waits: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE3
        (cfg.triggerActionSelect == dctc_pkg::ACT_BEAT && channelBusy && !mover.beatDone && !mover.blockDone
        && !enableClear) |=> channelBusy)
        else $error("beat transfer ended early");
    chk_list_continues: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE6
        (channelBusy && mover.blockDone && !mover.lastDescriptor && !enableClear)
        |=> channelEnable)
        else $error("channel disabled before list end");
    chk_list_waits: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE6
        (channelBusy && mover.blockDone && !mover.lastDescriptor && !channelPending && !trigPulse && !enableClear)
        |=> !arbRequest && !channelBusy)
        else $error("channel did not wait for next block trigger");
    chk_xfer_enabled: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE6
        channelBusy
        |-> channelEnable)
        else $error("transfer on a disabled channel");
    chk_clear_stops: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE7
        enableClear
        |=> !channelEnable && !channelBusy && !channelPending)
        else $error("clear did not stop the channel");
    chk_enable_arms: assert property (@(posedge sys_clk) disable iff (!rstSyncN) // RULE7
        (s_q.state == dctc_pkg::ST_OFF && enableSet && !enableClear)
        |=> channelEnable && !arbRequest)
        else $error("enable not taken");
    cov_start: cover property (@(posedge sys_clk) disable iff (!rstSyncN) transferStart);
    cov_pending: cover property (@(posedge sys_clk) disable iff (!rstSyncN) channelPending && trigPulse);
    cov_disable: cover property (@(posedge sys_clk) disable iff (!rstSyncN) channelBusy && endOfList);
    cov_beat_end: cover property (@(posedge sys_clk) disable iff (!rstSyncN) channelBusy && mover.beatDone);
    cov_list_next: cover property (@(posedge sys_clk) disable iff (!rstSyncN)
        channelBusy && mover.blockDone && !mover.lastDescriptor);
endmodule

// [verilog/dctc_pkg.sv]
// package for the per-channel trigger control block
// Behaviour
// [RULE1] start only with request and arbiter grant
// [RULE2] software, peripheral or event request sources
// [RULE3] action 0x0 block, 0x2 beat, 0x3 transaction
// [RULE4] default action requests a whole block
// [RULE5] single descriptor: enable clears after block
// [RULE6] linked list: disable after last descriptor
// [RULE7] re-enabled channel waits for fresh trigger
// [RULE8] request during transfer held pending, flag set
// [RULE9] at most one pending request per channel
// [RULE10] further request while pending is discarded
package dctc_pkg;
    localparam logic [1:0] ACT_BLOCK = 2'h0;
    localparam logic [1:0] ACT_BEAT = 2'h2;
    localparam logic [1:0] ACT_TRANSACTION = 2'h3;
    localparam logic [1:0] ACT_RESET = ACT_BLOCK;
    localparam logic [1:0] SRC_SOFTWARE = 2'h0;
    localparam logic [1:0] SRC_PERIPHERAL = 2'h1;
    localparam logic [1:0] SRC_EVENT = 2'h2;
    localparam logic [1:0] SRC_RESET = SRC_SOFTWARE;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_WAIT,
        ST_REQ,
        ST_XFER
    } dctc_state_e;

    typedef struct packed {
        logic swTrigger;
        logic periphReq;
        logic eventIn;
    } dctc_trig_s;

    typedef struct packed {
        logic [1:0] triggerSourceSelect;
        logic [1:0] triggerActionSelect;
    } dctc_cfg_s;

    // unit completion reported by the data mover
    typedef struct packed {
        logic beatDone;
        logic transactionDone;
        logic blockDone;
        logic lastDescriptor;
    } dctc_mover_s;

    typedef struct packed {
        dctc_state_e state;
        logic channelEnable;
        logic pending;
        logic busy;
        logic arbReq;
        logic startPulse;
    } dctc_state_s;
endpackage

// [verilog/dctc_trigger_detect.sv]
// trigger source selection and rising edge detection
`timescale 1ns/100ps
module dctc_trigger_detect (
    input wire logic sys_clk,
    input wire logic rstSyncN,
    input wire dctc_pkg::dctc_trig_s trig,
    input wire logic [1:0] sourceSel,
    output logic trigPulse
);
    logic selLevel;
    logic prev_q;

    always_comb begin
        case (sourceSel)
            dctc_pkg::SRC_SOFTWARE: selLevel = trig.swTrigger; // RULE2
            dctc_pkg::SRC_PERIPHERAL: selLevel = trig.periphReq; // RULE2
            dctc_pkg::SRC_EVENT: selLevel = trig.eventIn; // RULE2
            default: selLevel = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= selLevel;
        end
    end

    // edge detection so a held level counts as one request
    assign trigPulse = selLevel & ~prev_q;
endmodule

// [tb/dctc_far_model.sv]
// arbiter and data mover stand-in facing one channel
`timescale 1ns/100ps
module dctc_far_model (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic arbRequest,
    input wire logic transferStart,
    input wire logic [1:0] action,
    input wire logic lastDesc,
    input wire logic [2:0] grantDelay,
    input wire logic [3:0] xferLen,
    output logic grant,
    output dctc_pkg::dctc_mover_s mover
);
    logic [2:0] waitQ;
    logic [3:0] lenQ;
    logic runQ;
    logic lastUnit;
    assign lastUnit = runQ && !transferStart && lenQ == 4'h0;
    // grant stays up while the request holds so a slow arbiter never retracts it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            grant <= 1'b0;
            waitQ <= 3'h0;
            runQ <= 1'b0;
            lenQ <= 4'h0;
            mover <= '0;
        end else begin
            grant <= arbRequest && (grant || waitQ >= grantDelay);
            waitQ <= arbRequest ? waitQ + 3'h1 : 3'h0;
            if (transferStart) begin
                runQ <= 1'b1;
                lenQ <= xferLen;
            end else if (runQ) begin
                lenQ <= lenQ - 4'h1;
                runQ <= lenQ != 4'h0;
            end
            // each completion field written once per edge: a one-cycle pulse at the end of the unit
            mover.beatDone <= lastUnit && action == dctc_pkg::ACT_BEAT;
            mover.transactionDone <= lastUnit && action == dctc_pkg::ACT_TRANSACTION;
            mover.blockDone <= lastUnit && !action[1];
            mover.lastDescriptor <= lastUnit && lastDesc && !action[1];
        end
    end
endmodule

// [tb/dctc_channel_bench.sv]
// self-checking bench for one trigger-controlled channel
`timescale 1ns/100ps
module dctc_channel_bench;
    logic sys_clk, rstn, enableSet, enableClear, lastDesc, grant;
    logic channelEnable, channelPending, channelBusy, arbRequest, transferStart;
    dctc_pkg::dctc_trig_s trig;
    dctc_pkg::dctc_cfg_s cfg;
    dctc_pkg::dctc_mover_s mover;
    logic [2:0] grantDelay;
    logic [3:0] xferLen;
    logic [1:0] expQ[$];
    logic [1:0] acts[3] = '{dctc_pkg::ACT_BLOCK, dctc_pkg::ACT_BEAT, dctc_pkg::ACT_TRANSACTION};
    int mismatches = 0, checks = 0, cycles = 0;
    integer seed = 8135;
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    dctc_channel dut (.sys_clk(sys_clk), .rstn(rstn), .trig(trig), .cfg(cfg), .enableSet(enableSet),
        .enableClear(enableClear), .grant(grant), .mover(mover), .channelEnable(channelEnable),
        .channelPending(channelPending), .channelBusy(channelBusy), .arbRequest(arbRequest),
        .transferStart(transferStart));
    dctc_far_model far (.sys_clk(sys_clk), .rstn(rstn), .arbRequest(arbRequest), .transferStart(transferStart),
        .action(cfg.triggerActionSelect), .lastDesc(lastDesc), .grantDelay(grantDelay), .xferLen(xferLen),
        .grant(grant), .mover(mover));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cmp_snap(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        cmp_snap({1'b0, got}, {1'b0, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic fire(input logic [2:0] v);
        trig <= v;
        tick(1);
        trig <= 3'h0;
        tick(1);
    endtask
    task automatic enable();
        enableSet <= 1'b1;
        tick(1);
        enableSet <= 1'b0;
    endtask
    task automatic settle();
        tick(2);
        while (channelBusy !== 1'b0 || arbRequest !== 1'b0 || channelPending !== 1'b0) tick(1);
    endtask
    // every start is matched against the oldest note; an unplanned start meets an unknown note
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            give_verdict();
        end
        if (transferStart === 1'b1) begin
            if (expQ.size() == 0) expQ.push_back(2'bXX);
            cmp_snap({channelEnable, channelPending}, expQ.pop_front());
        end
    end
    initial begin
        logic [1:0] src;
        logic ld;
        rstn = 1'b0;
        enableSet = 1'b0;
        enableClear = 1'b0;
        lastDesc = 1'b1;
        trig = 3'h0;
        cfg = 4'h0;
        grantDelay = 3'h0;
        xferLen = 4'h2;
        tick(10);
        rstn <= 1'b1;
        tick(4);
        fire(3'h4);
        enable();
        expQ.push_back(2'h2);
        fire(3'h4);
        settle();
        cmp_flag(channelEnable, 1'b0);
        enable();
        tick(8);
        expQ.push_back(2'h2);
        fire(3'h4);
        settle();
        for (int i = 0; i < 9; i++) begin
            src = 2'(i % 3);
            ld = 1'($random(seed));
            lastDesc <= ld;
            cfg <= {src, acts[i / 3]};
            grantDelay <= 3'($random(seed));
            xferLen <= 4'($random(seed));
            enable();
            fire(3'($random(seed)) & ~(3'h4 >> src));
            expQ.push_back(2'h2);
            fire(3'h4 >> src);
            settle();
            cmp_flag(channelEnable, !(ld && !acts[i / 3][1]));
        end
        lastDesc <= 1'b0;
        grantDelay <= 3'h0;
        cfg <= 4'h0;
        xferLen <= 4'hF;
        enable();
        expQ.push_back(2'h2);
        expQ.push_back(2'h2);
        fire(3'h4);
        tick(3);
        fire(3'h4);
        tick(1);
        cmp_flag(channelPending, 1'b1);
        fire(3'h4);
        cmp_flag(channelPending, 1'b1);
        settle();
        expQ.push_back(2'h2);
        fire(3'h4);
        tick(3);
        fire(3'h4);
        tick(1);
        enableClear <= 1'b1;
        tick(1);
        enableClear <= 1'b0;
        tick(1);
        cmp_flag(channelPending, 1'b0);
        cmp_flag(channelEnable, 1'b0);
        enableSet <= 1'b1;
        enableClear <= 1'b1;
        tick(1);
        enableSet <= 1'b0;
        enableClear <= 1'b0;
        tick(1);
        cmp_flag(channelEnable, 1'b0);
        tick(30);
        cfg <= 4'hC;
        enable();
        fire(3'h7);
        tick(2);
        cmp_flag(arbRequest, 1'b0);
        cfg <= 4'h0;
        expQ.push_back(2'h2);
        fire(3'h4);
        tick(2);
        rstn <= 1'b0;
        tick(2);
        cmp_flag(channelBusy, 1'b0);
        cmp_flag(channelEnable, 1'b0);
        rstn <= 1'b1;
        tick(4);
        cmp_flag(arbRequest, 1'b0);
        cmp_flag(expQ.size() != 0, 1'b0);
        give_verdict();
    end
endmodule
